// [swdt_regs.vh]
// register map, field positions, reset values and timing constants of the supervision timer
`ifndef SWDT_REGS_VH
`define SWDT_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define SWDT_ADDR_MODE_SELECT    8'h4d
`define SWDT_ADDR_WDOG_CONFIG    8'h55

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define SWDT_MODE_RESET          8'h00
`define SWDT_CONFIG_RESET        8'h00
`define SWDT_MODE_WR_MASK        8'h0f

// ****************************************************************
// field positions
// ****************************************************************
`define SWDT_MODE_INDEP_BIT      3
`define SWDT_CFG_TIMEOUT_MSB     2
`define SWDT_CFG_TIMEOUT_LSB     0
`define SWDT_CFG_STARTUP_MSB     4
`define SWDT_CFG_STARTUP_LSB     3
`define SWDT_CFG_ENABLE_BIT      5
`define SWDT_CFG_STARTUP_EN_BIT  6
`define SWDT_CFG_RESET_EN_BIT    7

// ****************************************************************
// time base: one tick per microsecond
// ****************************************************************
`define SWDT_CLK_MHZ             50
`define SWDT_TICK_US             1
`define SWDT_TICK_CYCLES         (`SWDT_CLK_MHZ * `SWDT_TICK_US)
`define SWDT_CNT_W               27
`define SWDT_FAULT_LOW_CYCLES    2'd3

// ****************************************************************
// normal timeout periods in microseconds
// ****************************************************************
`define SWDT_TO_1MS              27'd1000
`define SWDT_TO_4MS              27'd4000
`define SWDT_TO_12MS5            27'd12500
`define SWDT_TO_50MS             27'd50000
`define SWDT_TO_200MS            27'd200000
`define SWDT_TO_800MS            27'd800000
`define SWDT_TO_1S6              27'd1600000
`define SWDT_TO_3S2              27'd3200000

// ****************************************************************
// long startup periods in microseconds
// ****************************************************************
`define SWDT_SU_25S6             27'd25600000
`define SWDT_SU_51S2             27'd51200000
`define SWDT_SU_102S4            27'd102400000
`define SWDT_SU_128S             27'd128000000

// ****************************************************************
// reset pulse durations in microseconds
// ****************************************************************
`define SWDT_RP_25US             27'd25
`define SWDT_RP_2MS              27'd2000
`define SWDT_RP_25MS             27'd25000
`define SWDT_RP_100MS            27'd100000
`define SWDT_RP_200MS            27'd200000
`define SWDT_RP_400MS            27'd400000
`define SWDT_RP_800MS            27'd800000
`define SWDT_RP_1600MS           27'd1600000

`endif

// [swdt_system_watchdog_timer.v]
// supervision timer of a multi-rail system manager, with its two configuration registers
`timescale 1ns/10ps
`include "swdt_regs.vh"

module swdt_system_watchdog_timer #(
    parameter P_TICK_CYCLES = `SWDT_TICK_CYCLES
) (
    // clock and reset
    input  wire       i_mclk,
    input  wire       i_rst,
    // register port
    input  wire       i_reg_wr_en,
    input  wire       i_reg_rd_en,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wr_data,
    input  wire [2:0] i_reset_timeout_code,
    output reg  [7:0] o_reg_rd_data,
    // pins from outside the clock domain
    input  wire       i_watchdog_strobe_input,
    input  wire       i_manual_reset_input_n,
    input  wire       i_enable_pin,
    // status from the rest of the manager
    input  wire       i_supply_above_lockout,
    input  wire       i_boot_done,
    input  wire       i_soft_reboot,
    input  wire       i_sequencing_done,
    input  wire       i_sequencer_reset,
    // outputs
    output reg        o_watchdog_fault_output_n,
    output reg        o_watchdog_reset_pulse,
    output wire       o_system_reset,
    output reg        o_supervision_active
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [2:0] ST_IDLE    = 3'd0;
    localparam [2:0] ST_STARTUP = 3'd1;
    localparam [2:0] ST_NORMAL  = 3'd2;
    localparam [2:0] ST_FAULT   = 3'd3;
    localparam [2:0] ST_FLT_RST = 3'd4;
    localparam [2:0] ST_PULSE   = 3'd5;

    // last prescaler count, cut to the prescaler width on purpose
    localparam [15:0] TICK_LAST = P_TICK_CYCLES[15:0] - 16'h0001;

    // ****************************************************************
    // period decoders
    // ****************************************************************
    // every period below counts one-microsecond ticks
    // normal timeout in ticks
    function [`SWDT_CNT_W-1:0] f_timeout;
        input [2:0] code;
        begin
            case (code)
                3'd0:    f_timeout = `SWDT_TO_1MS;
                3'd1:    f_timeout = `SWDT_TO_4MS;
                3'd2:    f_timeout = `SWDT_TO_12MS5;
                3'd3:    f_timeout = `SWDT_TO_50MS;
                3'd4:    f_timeout = `SWDT_TO_200MS;
                3'd5:    f_timeout = `SWDT_TO_800MS;
                3'd6:    f_timeout = `SWDT_TO_1S6;
                default: f_timeout = `SWDT_TO_3S2;
            endcase
        end
    endfunction

    // long startup period in ticks
    function [`SWDT_CNT_W-1:0] f_startup;
        input [1:0] code;
        begin
            case (code)
                2'd0:    f_startup = `SWDT_SU_25S6;
                2'd1:    f_startup = `SWDT_SU_51S2;
                2'd2:    f_startup = `SWDT_SU_102S4;
                default: f_startup = `SWDT_SU_128S;
            endcase
        end
    endfunction

    // reset pulse duration in ticks
    function [`SWDT_CNT_W-1:0] f_pulse;
        input [2:0] code;
        begin
            case (code)
                3'd0:    f_pulse = `SWDT_RP_25US;
                3'd1:    f_pulse = `SWDT_RP_2MS;
                3'd2:    f_pulse = `SWDT_RP_25MS;
                3'd3:    f_pulse = `SWDT_RP_100MS;
                3'd4:    f_pulse = `SWDT_RP_200MS;
                3'd5:    f_pulse = `SWDT_RP_400MS;
                3'd6:    f_pulse = `SWDT_RP_800MS;
                default: f_pulse = `SWDT_RP_1600MS;
            endcase
        end
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    // configuration registers
    reg  [7:0]             mode_reg;
    reg  [7:0]             cfg_reg;

    // pin synchronisers and strobe edge flop
    reg  [1:0]             strobe_sync_reg;
    reg                    strobe_prev_reg;
    reg  [1:0]             mr_sync_reg;
    reg  [1:0]             en_sync_reg;

    // supervision state and counters
    reg  [2:0]             state_reg;
    reg  [2:0]             state_next;
    reg  [`SWDT_CNT_W-1:0] cnt_reg;
    reg  [`SWDT_CNT_W-1:0] cnt_next;
    reg  [15:0]            presc_reg;
    reg  [1:0]             flt_cnt_reg;
    reg  [1:0]             flt_cnt_next;

    // decoded conditions
    reg                    load;
    wire                   tick;
    wire                   strobe_edge;
    wire                   indep;
    wire                   allowed;
    wire                   cnt_done;

    // mode, strobe edge, tick and expiry
    assign indep       = mode_reg[`SWDT_MODE_INDEP_BIT];
    assign strobe_edge = strobe_sync_reg[1] ^ strobe_prev_reg;
    assign tick        = (presc_reg == TICK_LAST);
    assign cnt_done    = (cnt_reg == {`SWDT_CNT_W{1'b0}});

    // conditions under which supervision may run; anything else is a reset event
    // in independent mode the sequencer terms drop out
    assign allowed = en_sync_reg[1] & cfg_reg[`SWDT_CFG_ENABLE_BIT]
                   & i_supply_above_lockout & i_boot_done & ~i_soft_reboot
                   & mr_sync_reg[1]
                   & (indep | (i_sequencing_done & ~i_sequencer_reset));

    // system reset seen by the board: sequencer request or watchdog pulse
    assign o_system_reset = i_sequencer_reset | o_watchdog_reset_pulse;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // writes land on the printed offsets; mode bits 7:4 stay zero, bits 3:0 are writable
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg      <= `SWDT_MODE_RESET;
            cfg_reg       <= `SWDT_CONFIG_RESET;
            o_reg_rd_data <= 8'h00;
        end else begin
            if (i_reg_wr_en && i_reg_addr == `SWDT_ADDR_MODE_SELECT) begin
                mode_reg <= i_reg_wr_data & `SWDT_MODE_WR_MASK;
            end
            if (i_reg_wr_en && i_reg_addr == `SWDT_ADDR_WDOG_CONFIG) begin
                cfg_reg <= i_reg_wr_data;
            end
            // read data is registered and holds until the next read
            if (i_reg_rd_en) begin
                case (i_reg_addr)
                    `SWDT_ADDR_MODE_SELECT: o_reg_rd_data <= mode_reg;
                    `SWDT_ADDR_WDOG_CONFIG: o_reg_rd_data <= cfg_reg;
                    default:                o_reg_rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // two flops per pin; the strobe gets a third for edge detection
    // enable resets low, so the first enable after reset is a fresh rise
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            strobe_sync_reg <= 2'b00;
            strobe_prev_reg <= 1'b0;
            mr_sync_reg     <= 2'b11;
            en_sync_reg     <= 2'b00;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[0], i_watchdog_strobe_input};
            strobe_prev_reg <= strobe_sync_reg[1];
            mr_sync_reg     <= {mr_sync_reg[0], i_manual_reset_input_n};
            en_sync_reg     <= {en_sync_reg[0], i_enable_pin};
        end
    end

    // ****************************************************************
    // microsecond prescaler
    // ****************************************************************
    // restarts on every load so each period starts on a whole tick
    // with one cycle per tick the count stays at zero and ticks every cycle
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            presc_reg <= 16'h0000;
        end else if (load || tick) begin
            presc_reg <= 16'h0000;
        end else begin
            presc_reg <= presc_reg + 16'h0001;
        end
    end

    // ****************************************************************
    // supervision state machine
    // ****************************************************************
    always @* begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        flt_cnt_next = flt_cnt_reg;
        load         = 1'b0;

        // count down one per tick, stop at zero
        if (tick && !cnt_done) begin
            cnt_next = cnt_reg - {{(`SWDT_CNT_W-1){1'b0}}, 1'b1};
        end
        case (state_reg)
            // wait for every start condition, then load a period
            ST_IDLE: begin
                if (allowed) begin
                    load = 1'b1;
                    if (cfg_reg[`SWDT_CFG_STARTUP_EN_BIT]) begin
                        state_next = ST_STARTUP;
                        cnt_next   = f_startup(cfg_reg[`SWDT_CFG_STARTUP_MSB:
                                                       `SWDT_CFG_STARTUP_LSB]);
                    end else begin
                        state_next = ST_NORMAL;
                        cnt_next   = f_timeout(cfg_reg[`SWDT_CFG_TIMEOUT_MSB:
                                                       `SWDT_CFG_TIMEOUT_LSB]);
                    end
                end
            end

            // a strobe edge reloads the timeout; expiry faults
            ST_STARTUP, ST_NORMAL: begin
                if (strobe_edge) begin
                    load       = 1'b1;
                    state_next = ST_NORMAL;
                    cnt_next   = f_timeout(cfg_reg[`SWDT_CFG_TIMEOUT_MSB:
                                                   `SWDT_CFG_TIMEOUT_LSB]);
                end else if (cnt_done) begin
                    if (cfg_reg[`SWDT_CFG_RESET_EN_BIT]) begin
                        state_next   = ST_FLT_RST;
                        flt_cnt_next = 2'd0;
                    end else begin
                        state_next = ST_FAULT;
                    end
                end
            end

            // fault holds until the processor strobes again
            ST_FAULT: begin
                if (strobe_edge) begin
                    load       = 1'b1;
                    state_next = ST_NORMAL;
                    cnt_next   = f_timeout(cfg_reg[`SWDT_CFG_TIMEOUT_MSB:
                                                   `SWDT_CFG_TIMEOUT_LSB]);
                end
            end

            ST_FLT_RST: begin
                // fault held low for three cycles before reset takes over
                flt_cnt_next = flt_cnt_reg + 2'd1;
                if (flt_cnt_reg == `SWDT_FAULT_LOW_CYCLES - 2'd1) begin
                    load       = 1'b1;
                    state_next = ST_PULSE;
                    cnt_next   = f_pulse(i_reset_timeout_code);
                end
            end

            // the pulse always runs its full length
            ST_PULSE: begin
                if (cnt_done) begin
                    state_next = ST_IDLE;
                end
            end

            // unused state codes fall back to idle
            default: begin
                state_next = ST_IDLE;
            end
        endcase

        // a lost supply, reboot or disable stops everything but a running pulse
        if (!allowed && state_reg != ST_PULSE) begin
            state_next = ST_IDLE;
            cnt_next   = {`SWDT_CNT_W{1'b0}};
        end
    end

    // state, counter and fault sequencing registers
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= {`SWDT_CNT_W{1'b0}};
            flt_cnt_reg <= 2'd0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            flt_cnt_reg <= flt_cnt_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // fault low while faulted or in its short pre-reset window
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_watchdog_fault_output_n <= 1'b1;
            o_watchdog_reset_pulse    <= 1'b0;
            o_supervision_active      <= 1'b0;
        end else begin
            o_watchdog_fault_output_n <= ~(state_next == ST_FAULT ||
                                           state_next == ST_FLT_RST);
            // reset pulse follows the end of the fault window
            o_watchdog_reset_pulse    <= (state_next == ST_PULSE);
            // active only in startup and normal supervision
            o_supervision_active      <= (state_next == ST_STARTUP ||
                                          state_next == ST_NORMAL);
        end
    end

endmodule // swdt_system_watchdog_timer

// [swdt_properties.sv]
// port-level checker of the supervision timer, bound to its top module
`timescale 1ns/10ps
`include "swdt_regs.vh"

module swdt_checker #(
    parameter P_TICK_CYCLES = 50
) (
    // clock and reset
    input wire       i_mclk,
    input wire       i_rst,
    // register port
    input wire       i_reg_wr_en,
    input wire       i_reg_rd_en,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wr_data,
    input wire [2:0] i_reset_timeout_code,
    input wire [7:0] o_reg_rd_data,
    // pins and status
    input wire       i_watchdog_strobe_input,
    input wire       i_manual_reset_input_n,
    input wire       i_enable_pin,
    input wire       i_supply_above_lockout,
    input wire       i_boot_done,
    input wire       i_soft_reboot,
    input wire       i_sequencing_done,
    input wire       i_sequencer_reset,
    // outputs
    input wire       o_watchdog_fault_output_n,
    input wire       o_watchdog_reset_pulse,
    input wire       o_system_reset,
    input wire       o_supervision_active
);
    reg  [7:0] mode_reg;
    reg  [7:0] cfg_reg;
    reg        en_prev_reg;
    wire       fault_n = o_watchdog_fault_output_n;
    wire       pulse   = o_watchdog_reset_pulse;
    wire       active  = o_supervision_active;
    // shadow copy of both registers, written on the same edge as the device
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg    <= `SWDT_MODE_RESET;
            cfg_reg     <= `SWDT_CONFIG_RESET;
            en_prev_reg <= 1'b0;
        end else begin
            if (i_reg_wr_en && i_reg_addr == `SWDT_ADDR_MODE_SELECT)
                mode_reg <= i_reg_wr_data & `SWDT_MODE_WR_MASK;
            if (i_reg_wr_en && i_reg_addr == `SWDT_ADDR_WDOG_CONFIG)
                cfg_reg <= i_reg_wr_data;
            en_prev_reg <= cfg_reg[`SWDT_CFG_ENABLE_BIT];
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_rdback;
        i_reg_rd_en && i_reg_addr == `SWDT_ADDR_MODE_SELECT |=> o_reg_rd_data == $past(mode_reg);
    endproperty
    a_rdback: assert property (p_rdback) else $error("mode readback wrong");
    property p_sysrst;
        o_system_reset == (i_sequencer_reset | pulse);
    endproperty
    a_sysrst: assert property (p_sysrst) else $error("system reset not the or of causes");
    property p_fault3;
        $rose(pulse) |-> $rose(fault_n) && !$past(fault_n, 3) && $past(fault_n, 4);
    endproperty
    a_fault3: assert property (p_fault3) else $error("fault not low three cycles");
    property p_pulse_len;
        $rose(pulse) && i_reset_timeout_code == 3'h0 && P_TICK_CYCLES == 1
            |-> pulse [*8] ##12 pulse ##[1:8] !pulse;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
    property p_dep_clear;
        !mode_reg[`SWDT_MODE_INDEP_BIT] && i_sequencer_reset |=> (fault_n && !active);
    endproperty
    a_dep_clear: assert property (p_dep_clear) else $error("timer not held by reset");
    property p_disabled;
        !cfg_reg[`SWDT_CFG_ENABLE_BIT] && !en_prev_reg |-> !active && fault_n;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled timer is running");
    property p_indep;
        mode_reg[`SWDT_MODE_INDEP_BIT] && i_sequencer_reset && active |=> active;
    endproperty
    a_indep: assert property (p_indep) else $error("sequencer reset stopped timer");
    property p_fault_no_rst;
        !cfg_reg[`SWDT_CFG_RESET_EN_BIT] && $fell(fault_n) |-> (!fault_n && !pulse) [*4];
    endproperty
    a_fault_no_rst: assert property (p_fault_no_rst) else $error("fault without hold");
endmodule // swdt_checker

bind swdt_system_watchdog_timer swdt_checker #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_checker (
    .i_mclk, .i_rst, .i_reg_wr_en, .i_reg_rd_en, .i_reg_addr, .i_reg_wr_data,
    .i_reset_timeout_code, .o_reg_rd_data, .i_watchdog_strobe_input,
    .i_manual_reset_input_n, .i_enable_pin, .i_supply_above_lockout, .i_boot_done,
    .i_soft_reboot, .i_sequencing_done, .i_sequencer_reset, .o_watchdog_fault_output_n,
    .o_watchdog_reset_pulse, .o_system_reset, .o_supervision_active
);

// [swdt_cpu_model.sv]
// model of the supervised processor that toggles the watchdog strobe
`timescale 1ns/10ps

module swdt_cpu_model (
    // clock and reset
    input  wire        i_mclk,
    input  wire        i_rst,
    // control from the bench
    input  wire        i_kick_en,
    input  wire [15:0] i_kick_period,
    input  wire        i_poke,
    // strobe toward the device
    output reg         o_strobe
);
    reg [15:0] cnt_reg;
    // toggle every i_kick_period plus one cycles while kicking, or once per poke; a level pin, held between edges
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg  <= 16'h0000;
            o_strobe <= 1'b0;
        end else begin
            cnt_reg <= (i_kick_en && cnt_reg < i_kick_period) ? cnt_reg + 16'h0001 : 16'h0000;
            if (i_poke || (i_kick_en && cnt_reg == i_kick_period))
                o_strobe <= ~o_strobe;
        end
    end
endmodule // swdt_cpu_model

// [tb_system_watchdog_timer.sv]
// self-checking bench of the supervision timer
`timescale 1ns/10ps
`include "swdt_regs.vh"

module tb_system_watchdog_timer;
    reg         i_mclk = 1'b0;
    reg         i_rst = 1'b1;
    reg         i_reg_wr_en = 1'b0;
    reg         i_reg_rd_en = 1'b0;
    reg  [7:0]  i_reg_addr = 8'h00;
    reg  [7:0]  i_reg_wr_data = 8'h00;
    reg  [2:0]  i_reset_timeout_code = 3'h0;
    reg  [4:0]  pins = 5'h1e; // enable, manual reset_n, lockout, boot, reboot
    reg         i_sequencing_done = 1'b1;
    reg         i_sequencer_reset = 1'b0;
    reg         kick_en = 1'b0;
    reg         poke = 1'b0;
    reg  [15:0] kick_per = 16'h0190;
    wire        strobe;
    wire [7:0]  o_reg_rd_data;
    wire        fault_n;
    wire        pulse;
    wire        sys_rst;
    wire        active;
    int         mismatches = 0;
    int         total_checks = 0;
    int         n;
    logic [7:0] v;
    logic [7:0] d;
    // ****************************************************************
    // clock, device and processor model
    // ****************************************************************
    initial forever #10 i_mclk = ~i_mclk;
    swdt_system_watchdog_timer #(.P_TICK_CYCLES(1)) uut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
        .i_reg_addr(i_reg_addr), .i_reg_wr_data(i_reg_wr_data),
        .i_reset_timeout_code(i_reset_timeout_code), .o_reg_rd_data(o_reg_rd_data),
        .i_watchdog_strobe_input(strobe), .i_manual_reset_input_n(pins[3]),
        .i_enable_pin(pins[4]), .i_supply_above_lockout(pins[2]), .i_boot_done(pins[1]),
        .i_soft_reboot(pins[0]), .i_sequencing_done(i_sequencing_done),
        .i_sequencer_reset(i_sequencer_reset), .o_watchdog_fault_output_n(fault_n),
        .o_watchdog_reset_pulse(pulse), .o_system_reset(sys_rst), .o_supervision_active(active));
    swdt_cpu_model cpu (.i_mclk(i_mclk), .i_rst(i_rst), .i_kick_en(kick_en),
        .i_kick_period(kick_per), .i_poke(poke), .o_strobe(strobe));
    // compare, register access and waiting helpers
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge i_mclk);
        i_reg_wr_en   <= 1'b1;
        i_reg_addr    <= a;
        i_reg_wr_data <= dat;
        @(posedge i_mclk);
        i_reg_wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge i_mclk);
        i_reg_rd_en <= 1'b1;
        i_reg_addr  <= a;
        @(posedge i_mclk);
        i_reg_rd_en <= 1'b0;
        #1 dat = o_reg_rd_data;
    endtask
    task automatic wait_sig(input int s, input logic val, input int lim, output int cnt);
        cnt = 0;
        while ((s ? pulse : fault_n) !== val && cnt < lim) begin
            @(posedge i_mclk);
            #1 cnt++;
        end
    endtask
    task do_poke;
        @(posedge i_mclk);
        poke <= 1'b1;
        @(posedge i_mclk);
        poke <= 1'b0;
    endtask
    function int exp_to(input int t);
        return t ? `SWDT_TO_4MS : `SWDT_TO_1MS;
    endfunction
    function int exp_rp(input int t);
        return t ? `SWDT_RP_2MS : `SWDT_RP_25US;
    endfunction
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog of the run itself
    initial begin
        repeat (40000) @(posedge i_mclk);
        mismatches++;
        final_report;
    end
    // main sequence
    initial begin
        void'($urandom(55654));
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(`SWDT_ADDR_MODE_SELECT, d);
        chk("mode reset", d, `SWDT_MODE_RESET);
        rd(`SWDT_ADDR_WDOG_CONFIG, d);
        chk("config reset", d, `SWDT_CONFIG_RESET);
        repeat (4) begin
            v = $urandom;
            wr(`SWDT_ADDR_MODE_SELECT, v);
            rd(`SWDT_ADDR_MODE_SELECT, d);
            chk("mode rw", d, v & `SWDT_MODE_WR_MASK);
            v = $urandom;
            wr(`SWDT_ADDR_WDOG_CONFIG, v);
            rd(`SWDT_ADDR_WDOG_CONFIG, d);
            chk("config rw", d, v);
            v = 8'h60 | 8'($urandom % 16);
            wr(v, 8'hff);
            rd(v, d);
            chk("unmapped", d, 8'h00);
        end
        wr(`SWDT_ADDR_WDOG_CONFIG, 8'h00);
        $display("test registers done");
        wr(`SWDT_ADDR_MODE_SELECT, 8'h08);
        for (int t = 0; t < 2; t++) begin
            i_reset_timeout_code <= t[2:0];
            wr(`SWDT_ADDR_WDOG_CONFIG, 8'ha0 | t[7:0]);
            wait_sig(0, 1'b0, 5000, n);
            chk("timeout", n >= exp_to(t) && n <= exp_to(t) + 8, 1);
            wait_sig(0, 1'b1, 20, n);
            chk("fault low", n, 3);
            chk("reset out", {pulse, sys_rst}, 2'b11);
            wait_sig(1, 1'b0, 3000, n);
            chk("pulse len", n >= exp_rp(t) && n <= exp_rp(t) + 2, 1);
            wr(`SWDT_ADDR_WDOG_CONFIG, 8'h00);
        end
        $display("test expiry with reset done");
        wr(`SWDT_ADDR_WDOG_CONFIG, 8'h20);
        kick_per <= 16'(200 + $urandom % 700);
        kick_en  <= 1'b1;
        wait_sig(0, 1'b0, 3000, n);
        chk("kept alive", n, 3000);
        @(posedge i_mclk) kick_en <= 1'b0;
        wait_sig(0, 1'b0, 1200, n);
        repeat (200) @(posedge i_mclk);
        #1 chk("fault held", {fault_n, sys_rst}, 2'b00);
        do_poke;
        wait_sig(0, 1'b1, 10, n);
        chk("fault cleared", fault_n, 1'b1);
        $display("test strobe supervision done");
        @(posedge i_mclk) kick_en <= 1'b1;
        i_sequencer_reset <= 1'b1;
        repeat (20) @(posedge i_mclk);
        #1 chk("indep active", active, 1'b1);
        wr(`SWDT_ADDR_MODE_SELECT, 8'h00);
        repeat (4) @(posedge i_mclk);
        #1 chk("dep held", {active, fault_n}, 2'b01);
        @(posedge i_mclk) i_sequencer_reset <= 1'b0;
        i_sequencing_done <= 1'b0;
        repeat (4) @(posedge i_mclk);
        #1 chk("dep no seq", active, 1'b0);
        @(posedge i_mclk) i_sequencing_done <= 1'b1;
        repeat (4) @(posedge i_mclk);
        #1 chk("dep run", active, 1'b1);
        $display("test modes done");
        @(posedge i_mclk) kick_en <= 1'b0;
        wr(`SWDT_ADDR_WDOG_CONFIG, 8'h00);
        wr(`SWDT_ADDR_WDOG_CONFIG, 8'h60);
        wait_sig(0, 1'b0, 3000, n);
        chk("startup", {n[30:0], active}, {31'd3000, 1'b1});
        do_poke;
        wait_sig(0, 1'b0, 1200, n);
        chk("first strobe", n >= 995 && n <= 1010, 1);
        for (int k = 0; k < 5; k++) begin
            @(posedge i_mclk);
            pins <= 5'h1e ^ (5'h10 >> k);
            repeat (5) @(posedge i_mclk);
            #1 chk("held off", {active, fault_n}, 2'b01);
            @(posedge i_mclk) pins <= 5'h1e;
            repeat (1200) @(posedge i_mclk);
            #1 chk("restart delay", {active, fault_n}, 2'b11);
        end
        $display("test reset events done");
        final_report;
    end
endmodule // tb_system_watchdog_timer
